// ### hw/pwsq_regs.svh
// register offsets, reset values and timing counts of the pwm and square-wave block
// assumes a 10 MHz module clock and a byte-addressed register port
`ifndef PWSQ_REGS_SVH
`define PWSQ_REGS_SVH

`define PWSQ_CLK_HZ 10000000
`define PWSQ_CLK_NS 100
`define PWSQ_TICK_NS 1000
`define PWSQ_TICK_CYC ((`PWSQ_TICK_NS + `PWSQ_CLK_NS - 1) / `PWSQ_CLK_NS)
`define PWSQ_PWM_MAX_HZ 1000000
`define PWSQ_SQ_MAX_HZ 4000000
`define PWSQ_SQ_MAX_INC ((64'd4000000 << 32) / 64'd10000000)

`define PWSQ_OFF_CTRL 8'h00
`define PWSQ_OFF_PERIOD 8'h04
`define PWSQ_OFF_SQINC 8'h08
`define PWSQ_OFF_STATUS 8'h0C
`define PWSQ_OFF_GPOUT 8'h10
`define PWSQ_OFF_GPOE 8'h14
`define PWSQ_OFF_FNSEL 8'h18
`define PWSQ_OFF_PINLVL 8'h1C
`define PWSQ_OFF_DUTY 8'h40

`define PWSQ_CTRL_PWM_BIT 0
`define PWSQ_CTRL_SQ_BIT 1
`define PWSQ_DUTY_SQ_LSB 16

`define PWSQ_RST_PERIOD 16'h03E8
`define PWSQ_RST_SQ_DUTY 8'h80

`endif

// ### hw/pwsq_pkg.sv
// types and shared helpers of the pwm and square-wave block
// assumes nothing beyond the header of constants
package pwsq_pkg;

   // pin function; gray order gpio -> pwm -> square
   typedef enum logic [1:0]
   {
      PWSQ_FN_GPIO = 2'h0,
      PWSQ_FN_PWM = 2'h1,
      PWSQ_FN_SQ = 2'h3,
      PWSQ_FN_RSVD = 2'h2
   } pwsq_fn_type;

   function automatic logic pwsq_pwm_level(input logic [15:0] cnt, input logic [15:0] duty,
                                           input logic [15:0] period);
   begin
      pwsq_pwm_level = (duty >= period) ? 1'b1 : (cnt < duty);
   end
   endfunction : pwsq_pwm_level

endpackage : pwsq_pkg

// ### hw/pwsq_pwm_base.sv
// shared pwm timebase: microsecond tick and period counter
// assumes period is never zero (the register file clamps it)
`timescale 1ns/100ps
`default_nettype none
`include "pwsq_regs.svh"

module pwsq_pwm_base #(
   parameter int TICK_CYC = `PWSQ_TICK_CYC,
   parameter int CW = 16
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic en_in,
   input wire logic [CW-1:0] period_in,
   output logic tick_out,
   output logic [CW-1:0] cnt_out
);
   import pwsq_pkg::*;

   localparam int PW = $clog2(TICK_CYC + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);

   logic [PW-1:0] pre;
   wire pre_wrap = (pre == PRE_LAST);
   wire cnt_wrap = (cnt_out >= period_in - CW'(1));

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pre <= '0;
         tick_out <= 1'b0;
         cnt_out <= '0;
      end
      else if (!en_in)
      begin
         pre <= '0;
         tick_out <= 1'b0;
         cnt_out <= '0;
      end
      else
      begin
         pre <= pre_wrap ? '0 : pre + PW'(1); // RULE_03
         tick_out <= pre_wrap;
         if (tick_out)
            cnt_out <= cnt_wrap ? '0 : cnt_out + CW'(1); // RULE_03
      end
   end

   // helper: cycles since the last tick, cleared while stopped; saturates so it never wraps
   logic [PW-1:0] gap;
   logic gap_seen;

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         gap <= '0;
         gap_seen <= 1'b0;
      end
      else if (!en_in)
      begin
         gap <= '0;
         gap_seen <= 1'b0;
      end
      else if (tick_out)
      begin
         gap <= '0;
         gap_seen <= 1'b1;
      end
      else if (!(&gap))
         gap <= gap + PW'(1);
   end

   // one step per microsecond while running: a tick exactly when the gap is PRE_LAST
   tick_step_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_03
      (en_in && gap_seen) |-> (gap <= PRE_LAST && tick_out == (gap == PRE_LAST)))
      else $error("pwm tick spacing wrong");

   // a period write may leave the counter high once; otherwise it stays below
   cnt_bound_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_03
      (en_in && cnt_out < period_in) |=> (cnt_out < period_in || $changed(period_in)))
      else $error("pwm counter past period");

endmodule : pwsq_pwm_base
`default_nettype wire

// ### hw/pwsq_sq_nco.sv
// common square-wave phase accumulator for all pins
// assumes the increment is already limited to the top rate
`timescale 1ns/100ps
`default_nettype none
`include "pwsq_regs.svh"

module pwsq_sq_nco #(
   parameter int AW = 32
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic en_in,
   input wire logic [AW-1:0] inc_in,
   output logic [AW-1:0] phase_out
);
   import pwsq_pkg::*;

   // zero increment freezes the phase, so every square-wave pin stays static
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         phase_out <= '0;
      else if (en_in)
         phase_out <= phase_out + inc_in; // RULE_05
   end

   sq_static_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_07
      (inc_in == '0 || !en_in) |=> $stable(phase_out))
      else $error("square phase moved while stopped");

   sq_step_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_05
      en_in |=> (phase_out == $past(phase_out) + $past(inc_in)))
      else $error("square phase step wrong");

endmodule : pwsq_sq_nco
`default_nettype wire

// ### hw/pwsq_top.sv
// pwm and square-wave generator with per-pin function select on 16 general pins
// assumes a 10 MHz clock and a single-cycle register port with read data one cycle later
`timescale 1ns/100ps
`default_nettype none
`include "pwsq_regs.svh"

//
// Contract
// (RULE_01) pwm period programmable in microseconds, fastest 1 MHz.
// (RULE_02) pwm duty settable from always off to always on.
// (RULE_03) duty steps are one microsecond, so steps equal period length.
// (RULE_04) any general pin may carry pwm, up to 16 at once.
// (RULE_05) square wave programmable from 0 Hz to 4 MHz, nominally 50 percent.
// (RULE_06) one common square frequency on all pins, duty set per pin.
// (RULE_07) pwm static low at zero, high at full; square static at 0 Hz.
module pwsq_top #(
   parameter int NPIN = 16,
   parameter int CW = 16
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [NPIN-1:0] general_pin_in,
   output logic [NPIN-1:0] general_pin_out,
   output logic [NPIN-1:0] general_pin_oe_n_out
);
   import pwsq_pkg::*;

   localparam logic [31:0] SQ_MAX = 32'(`PWSQ_SQ_MAX_INC);
   localparam logic [CW-1:0] PER_MIN =
      CW'(`PWSQ_CLK_HZ / `PWSQ_PWM_MAX_HZ / `PWSQ_TICK_CYC);

   // ****************************************************************
   // register file
   // ****************************************************************

   logic [1:0] ctrl;
   logic [CW-1:0] period;
   logic [31:0] sq_inc;
   logic [2*NPIN-1:0] fn_sel;
   logic [NPIN-1:0] gp_out;
   logic [NPIN-1:0] gp_oe;
   logic [NPIN-1:0] pin_lvl;
   logic [CW-1:0] pwm_duty [NPIN];
   logic [7:0] sq_duty [NPIN];

   wire wr_ctrl = reg_wr_in && (reg_addr_in == `PWSQ_OFF_CTRL);
   wire wr_period = reg_wr_in && (reg_addr_in == `PWSQ_OFF_PERIOD);
   wire wr_sqinc = reg_wr_in && (reg_addr_in == `PWSQ_OFF_SQINC);
   wire wr_gpout = reg_wr_in && (reg_addr_in == `PWSQ_OFF_GPOUT);
   wire wr_gpoe = reg_wr_in && (reg_addr_in == `PWSQ_OFF_GPOE);
   wire wr_fnsel = reg_wr_in && (reg_addr_in == `PWSQ_OFF_FNSEL);
   wire duty_hit = (reg_addr_in[7:6] == 2'(`PWSQ_OFF_DUTY >> 6));
   wire [3:0] duty_idx = reg_addr_in[5:2];
   wire wr_duty = reg_wr_in && duty_hit;

   wire pwm_en = ctrl[`PWSQ_CTRL_PWM_BIT];
   wire sq_en = ctrl[`PWSQ_CTRL_SQ_BIT];

   // clamp on write so the timebase never sees a rate above its limit
   wire [CW-1:0] wdata_per = reg_wdata_in[CW-1:0];
   wire [CW-1:0] next_period = (wdata_per < PER_MIN) ? PER_MIN : wdata_per; // RULE_01
   wire [31:0] next_sq_inc = (reg_wdata_in > SQ_MAX) ? SQ_MAX : reg_wdata_in; // RULE_05

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ctrl <= '0;
         period <= `PWSQ_RST_PERIOD;
         sq_inc <= '0;
         fn_sel <= '0;
         gp_out <= '0;
         gp_oe <= '0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= reg_wdata_in[1:0];
         if (wr_period)
            period <= next_period; // RULE_01
         if (wr_sqinc)
            sq_inc <= next_sq_inc; // RULE_05
         if (wr_fnsel)
            fn_sel <= reg_wdata_in[2*NPIN-1:0]; // RULE_04
         if (wr_gpout)
            gp_out <= reg_wdata_in[NPIN-1:0];
         if (wr_gpoe)
            gp_oe <= reg_wdata_in[NPIN-1:0];
      end
   end

   // per-pin duty words; square duty defaults to half the phase range
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         for (int i = 0; i < NPIN; i++)
         begin
            pwm_duty[i] <= '0;
            sq_duty[i] <= `PWSQ_RST_SQ_DUTY;
         end
      end
      else if (wr_duty)
      begin
         pwm_duty[duty_idx] <= reg_wdata_in[CW-1:0]; // RULE_02
         sq_duty[duty_idx] <= reg_wdata_in[`PWSQ_DUTY_SQ_LSB +: 8]; // RULE_06
      end
   end

   // ****************************************************************
   // timebases
   // ****************************************************************

   logic pwm_tick;
   logic [CW-1:0] pwm_cnt;
   logic [31:0] sq_phase;

   pwsq_pwm_base #(
      .TICK_CYC(`PWSQ_TICK_CYC),
      .CW(CW)
   ) u_pwm_base (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .en_in(pwm_en),
      .period_in(period),
      .tick_out(pwm_tick),
      .cnt_out(pwm_cnt)
   );

   pwsq_sq_nco #(
      .AW(32)
   ) u_sq_nco (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .en_in(sq_en),
      .inc_in(sq_inc),
      .phase_out(sq_phase)
   );

   // ****************************************************************
   // pin multiplexer
   // ****************************************************************

   logic [NPIN-1:0] pwm_lvl;
   logic [NPIN-1:0] sq_lvl;
   logic [NPIN-1:0] next_pin;
   logic [NPIN-1:0] next_oe_n;

   for (genvar g = 0; g < NPIN; g++)
   begin : g_pin
      wire pwsq_fn_type fn = pwsq_fn_type'(fn_sel[2*g +: 2]);
      // a shared counter keeps every pwm pin phase aligned
      assign pwm_lvl[g] = pwm_en && pwsq_pwm_level(pwm_cnt, pwm_duty[g], period); // RULE_02
      // one phase for all pins, each with its own threshold
      assign sq_lvl[g] = sq_en && (sq_phase[31:24] < sq_duty[g]); // RULE_06
      assign next_pin[g] = (fn == PWSQ_FN_PWM) ? pwm_lvl[g] : // RULE_04
                           (fn == PWSQ_FN_SQ) ? sq_lvl[g] :
                           gp_out[g];
      assign next_oe_n[g] = (fn == PWSQ_FN_PWM || fn == PWSQ_FN_SQ) ? 1'b0 : ~gp_oe[g];
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         general_pin_out <= '0;
         general_pin_oe_n_out <= '1;
         pin_lvl <= '0;
      end
      else
      begin
         general_pin_out <= next_pin; // RULE_04
         general_pin_oe_n_out <= next_oe_n;
         pin_lvl <= general_pin_in;
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************

   wire [31:0] status = {sq_phase[31], 15'h0000, pwm_cnt};
   wire [31:0] duty_word = {8'h00, sq_duty[duty_idx], pwm_duty[duty_idx]};
   wire [31:0] next_rdata =
      !reg_rd_in ? 32'h00000000 :
      (reg_addr_in == `PWSQ_OFF_CTRL) ? {30'h00000000, ctrl} :
      (reg_addr_in == `PWSQ_OFF_PERIOD) ? {16'h0000, period} :
      (reg_addr_in == `PWSQ_OFF_SQINC) ? sq_inc :
      (reg_addr_in == `PWSQ_OFF_STATUS) ? status :
      (reg_addr_in == `PWSQ_OFF_GPOUT) ? {16'h0000, gp_out} :
      (reg_addr_in == `PWSQ_OFF_GPOE) ? {16'h0000, gp_oe} :
      (reg_addr_in == `PWSQ_OFF_FNSEL) ? fn_sel :
      (reg_addr_in == `PWSQ_OFF_PINLVL) ? {16'h0000, pin_lvl} :
      duty_hit ? duty_word :
      32'h00000000;

   // unmapped addresses read zero, writes to them are dropped
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         reg_rdata_out <= '0;
      else
         reg_rdata_out <= next_rdata;
   end

   // ****************************************************************
   // checks
   // ****************************************************************

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   period_floor_a: assert property (period >= PER_MIN) // RULE_01
      else $error("pwm period below limit");

   period_wr_a: assert property (wr_period |=> period == $past(next_period)) // RULE_01
      else $error("pwm period write lost");

   pwm_zero_a: assert property ( // RULE_07
      (fn_sel[3:2] == 2'h1 && pwm_duty[1] == '0) |=> !general_pin_out[1])
      else $error("zero duty pin not low");

   pwm_full_a: assert property ( // RULE_07
      (fn_sel[5:4] == 2'h1 && pwm_en && pwm_duty[2] >= period) |=> general_pin_out[2])
      else $error("full duty pin not high");

   pwm_follow_a: assert property ( // RULE_02
      (fn_sel[1:0] == 2'h1 && pwm_en && pwm_duty[0] < period)
      |=> general_pin_out[0] == ($past(pwm_cnt) < $past(pwm_duty[0])))
      else $error("pwm pin does not track counter");

   sq_limit_a: assert property (sq_inc <= SQ_MAX) // RULE_05
      else $error("square rate above limit");

   // shared phase: a pin with the lower threshold is high only while the other is
   sq_common_a: assert property ( // RULE_06
      (fn_sel[9:6] == 4'hF && sq_duty[3] >= sq_duty[4])
      |=> (!general_pin_out[4] || general_pin_out[3]))
      else $error("square pins out of step");

   pin_drive_a: assert property ( // RULE_04
      (fn_sel[1:0] == 2'h1 || fn_sel[1:0] == 2'h3) |=> !general_pin_oe_n_out[0])
      else $error("alternate pin not driven");

endmodule : pwsq_top
`default_nettype wire

// ### verif/tb.sv
// self-checking bench of the pwm and square-wave block, driven over its register port
// assumes a 10 MHz clock and read data one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
`include "pwsq_regs.svh"

module tb;
   import pwsq_pkg::*;
   logic clk_in;
   logic rstn_in;
   logic [7:0] reg_addr_in;
   logic [31:0] reg_wdata_in;
   logic reg_wr_in;
   logic reg_rd_in;
   logic [31:0] reg_rdata_out;
   logic [15:0] general_pin_in;
   logic [15:0] general_pin_out;
   logic [15:0] general_pin_oe_n_out;
   int err_total;
   int checks_done;
   int hi [16];
   int chg [16];
   logic [31:0] rd_val;

   pwsq_top uut (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out),
      .general_pin_in(general_pin_in),
      .general_pin_out(general_pin_out),
      .general_pin_oe_n_out(general_pin_oe_n_out)
   );

   // ************************************************
   // clock, bus tasks and comparison
   // ************************************************
   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
   begin
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   end
   endtask : wr

   // data stand only in the cycle after the strobe, so sample mid-cycle there
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
   begin
      @(posedge clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      d = reg_rdata_out;
   end
   endtask : rd

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
   begin
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   end
   endtask : chk

   task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
   begin
      rd(a, rd_val);
      chk(name, exp, rd_val);
   end
   endtask : rchk

   // whole periods are counted, so the result does not depend on phase
   task automatic measure(input int n);
      logic [15:0] prev;
   begin
      @(negedge clk_in);
      prev = general_pin_out;
      for (int i = 0; i < 16; i++)
      begin
         hi[i] = 0;
         chg[i] = 0;
      end
      repeat (n)
      begin
         @(negedge clk_in);
         for (int i = 0; i < 16; i++)
         begin
            if (general_pin_out[i] === 1'b1)
               hi[i]++;
            if (general_pin_out[i] !== prev[i])
               chg[i]++;
         end
         prev = general_pin_out;
      end
   end
   endtask : measure

   task automatic complete_run;
   begin
      if (err_total == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask : complete_run

   // ************************************************
   // watchdog
   // ************************************************
   initial
   begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      complete_run();
   end

   // ************************************************
   // test sequence
   // ************************************************
   initial
   begin
      err_total = 0;
      checks_done = 0;
      rstn_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 32'h0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      general_pin_in = 16'hA5C3;
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(negedge clk_in);
      chk("oe_n reset", 32'h0000FFFF, {16'h0, general_pin_oe_n_out});
      chk("pin reset", 32'h0, {16'h0, general_pin_out});
      rchk("period reset", `PWSQ_OFF_PERIOD, {16'h0, `PWSQ_RST_PERIOD});
      rchk("sq duty reset", `PWSQ_OFF_DUTY, {8'h0, `PWSQ_RST_SQ_DUTY, 16'h0});
      rchk("status reset", `PWSQ_OFF_STATUS, 32'h0);
      rchk("unmapped", 8'h3C, 32'h0);
      rchk("pin level", `PWSQ_OFF_PINLVL, 32'h0000A5C3);
      wr(`PWSQ_OFF_PERIOD, 32'h0);
      rchk("period floor", `PWSQ_OFF_PERIOD, 32'h1);
      wr(`PWSQ_OFF_SQINC, 32'hFFFFFFFF);
      rchk("sq clamp", `PWSQ_OFF_SQINC, 32'h66666666);
      // pins 0..2 pwm, 3..4 square, 5 gpio, 6 spare code acting as gpio
      wr(`PWSQ_OFF_FNSEL, 32'h000023D5);
      wr(`PWSQ_OFF_GPOUT, 32'h20);
      wr(`PWSQ_OFF_GPOE, 32'h20);
      wr(`PWSQ_OFF_PERIOD, 32'h4);
      wr(`PWSQ_OFF_DUTY, 32'h00800002);
      wr(`PWSQ_OFF_DUTY + 8'h04, 32'h00800000);
      wr(`PWSQ_OFF_DUTY + 8'h08, 32'h00800004);
      wr(`PWSQ_OFF_DUTY + 8'h10, 32'h00400000);
      wr(`PWSQ_OFF_SQINC, 32'h40000000);
      wr(`PWSQ_OFF_CTRL, 32'h3);
      rchk("ctrl set", `PWSQ_OFF_CTRL, 32'h3);
      repeat (60) @(posedge clk_in);
      measure(400);
      chk("oe_n active", 32'h0000FFC0, {16'h0, general_pin_oe_n_out});
      chk("gpio drive", 32'h1, {31'h0, general_pin_out[5]});
      chk("pwm half", 32'd200, hi[0]);
      chk("pwm zero", 32'd0, hi[1]);
      chk("pwm full", 32'd400, hi[2]);
      chk("sq half", 32'd200, hi[3]);
      chk("sq quarter", 32'd100, hi[4]);
      chk("sq edges a", 32'd200, chg[3]);
      chk("sq edges b", 32'd200, chg[4]);
      // 500 kHz gives two duty steps
      wr(`PWSQ_OFF_PERIOD, 32'h2);
      wr(`PWSQ_OFF_DUTY, 32'h00800001);
      wr(`PWSQ_OFF_SQINC, 32'h0);
      repeat (60) @(posedge clk_in);
      measure(200);
      chk("pwm 1of2", 32'd100, hi[0]);
      chk("pwm 1of2 edges", 32'd20, chg[0]);
      chk("sq frozen", 32'd0, chg[3]);
      complete_run();
   end
endmodule : tb
`default_nettype wire
